// *** core/sac_map.vh ***
// Register map, field positions, reset values and timing counts of the converter control.
// Assumes inclusion by bare name from the design files of this block only.
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SAC_OFS_CSR 8'h34
`define SAC_OFS_RESULT 8'h35
`define SAC_OFS_AMP 8'h36

// ----------------------------------------
// Control/status fields
// ----------------------------------------
`define SAC_CSR_DONE 7
`define SAC_CSR_SPEED 6
`define SAC_CSR_ON 5
`define SAC_CSR_CH_HI 2
`define SAC_CSR_CH_LO 0
`define SAC_CSR_WMASK 8'h67

// ----------------------------------------
// Amplifier/clock fields
// ----------------------------------------
`define SAC_AMP_SLOW 3
`define SAC_AMP_GAIN 2
`define SAC_AMP_WMASK 8'h0c

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define SAC_RST_BYTE 8'h00
`define SAC_CH_MAX 3'h4
`define SAC_DIV_FULL 2'h0
`define SAC_DIV_HALF 2'h1
`define SAC_DIV_QUARTER 2'h3
`define SAC_SAMPLE_TICKS 4'h4
`define SAC_STABLE_TICKS 8'h40
`define SAC_MSB_MASK 8'h80

`endif

// *** core/sac_clkdiv.v ***
// Converter clock tick generator, derived from the processor clock.
// Assumes the parent passes a divide code of 0, 1 or 3 and a run enable.
`timescale 1ns/1ps
`include "sac_map.vh"

module sac_clkdiv (
    input wire mclk,
    input wire sys_rst,
    input wire ce,
    input wire run,
    input wire [1:0] div_code,
    output reg tick
);

    reg [1:0] count;

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    // Counts up to div_code, one tick per wrap; stopped while off to save power
    always @(posedge mclk) begin
        if (sys_rst) begin
            count <= 2'h0;
            tick <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                count <= 2'h0;
                tick <= 1'b0;
            end else if (count >= div_code) begin
                count <= 2'h0;
                tick <= 1'b1;
            end else begin
                count <= count + 2'h1;
                tick <= 1'b0;
            end
        end
    end

endmodule

// *** core/sac_sar.v ***
// Successive-approximation sequencer: sample phase then eight trial steps.
// Assumes the comparator answers the trial value within one converter clock tick.
`timescale 1ns/1ps
`include "sac_map.vh"

module sac_sar #(
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire sys_rst,
    input wire ce,
    input wire tick,
    input wire run,
    input wire restart,
    input wire comp_high,
    output reg sampling,
    output reg [WIDTH-1:0] trial,
    output reg done,
    output reg [WIDTH-1:0] value
);

    localparam ST_IDLE = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_HOLD = 2'h2;

    reg [1:0] state;
    reg [3:0] samp_cnt;
    reg [WIDTH-1:0] bit_mask;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Restart wins over any step so an aborted conversion never completes
    always @(posedge mclk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            samp_cnt <= 4'h0;
            bit_mask <= {WIDTH{1'b0}};
            trial <= {WIDTH{1'b0}};
            sampling <= 1'b0;
            done <= 1'b0;
            value <= {WIDTH{1'b0}};
        end else if (ce) begin
            done <= 1'b0;
            if (!run || restart) begin
                state <= run ? ST_SAMPLE : ST_IDLE;
                samp_cnt <= 4'h0;
                sampling <= run;
                trial <= {WIDTH{1'b0}};
            end else if (tick) begin
                case (state)
                    ST_IDLE: begin
                        state <= ST_SAMPLE;
                        samp_cnt <= 4'h0;
                        sampling <= 1'b1;
                    end
                    ST_SAMPLE: begin
                        // Fixed sampling length in converter clocks
                        if (samp_cnt == `SAC_SAMPLE_TICKS - 4'h1) begin
                            state <= ST_HOLD;
                            sampling <= 1'b0;
                            bit_mask <= {1'b1, {(WIDTH-1){1'b0}}};
                            trial <= {1'b1, {(WIDTH-1){1'b0}}};
                        end else begin
                            samp_cnt <= samp_cnt + 4'h1;
                        end
                    end
                    ST_HOLD: begin
                        // One result bit per step, MSB first
                        if (bit_mask[0]) begin
                            value <= comp_high ? trial : (trial & ~bit_mask);
                            done <= 1'b1;
                            state <= ST_SAMPLE;
                            samp_cnt <= 4'h0;
                            sampling <= 1'b1;
                            trial <= {WIDTH{1'b0}};
                        end else begin
                            trial <= (comp_high ? trial : (trial & ~bit_mask)) | (bit_mask >> 1);
                            bit_mask <= bit_mask >> 1;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// *** core/sac_top.v ***
// Control logic of an 8-bit successive-approximation converter with register port.
// Assumes an external sample-and-hold and comparator; comp_high is synchronous to mclk.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "sac_map.vh"

module sac_top #(
    parameter WIDTH = 8,
    parameter STABLE_TICKS = `SAC_STABLE_TICKS
) (
    input wire mclk,
    input wire sys_rst,
    input wire ce,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire wait_mode,
    input wire halt_mode,
    input wire comp_high,
    output reg converter_power,
    output reg amplifier_power,
    output reg x8_gain_route,
    output reg [2:0] channel_sel_out,
    output wire sample_phase,
    output wire [WIDTH-1:0] trial_value
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg done_flag;
    reg speed;
    reg converter_on;
    reg [2:0] channel_select;
    reg slow;
    reg x8_gain_select;
    reg [WIDTH-1:0] conversion_result;
    reg [7:0] stable_cnt;
    reg halt_seen;

    wire hit_csr = (addr == `SAC_OFS_CSR);
    wire hit_result = (addr == `SAC_OFS_RESULT);
    wire hit_amp = (addr == `SAC_OFS_AMP);
    wire csr_write = wr && hit_csr;
    wire result_read = rd && hit_result;
    // Halt alone gates the converter; wait_mode is deliberately unused in logic
    wire run = converter_on && !halt_mode;
    wire restart = csr_write && wdata[`SAC_CSR_ON];
    wire stable = (stable_cnt == 8'h00);

    wire tick;
    wire sar_sampling;
    wire [WIDTH-1:0] sar_trial;
    wire sar_done;
    wire [WIDTH-1:0] sar_value;

    // Sequencer flops drive these pins directly: an extra register stage would show
    // the trial one mclk late, so full-rate steps would judge the previous trial
    assign sample_phase = sar_sampling;
    assign trial_value = sar_trial;

    // ----------------------------------------
    // Clock selection
    // ----------------------------------------
    // Slow overrides speed
    wire [1:0] div_code = slow ? `SAC_DIV_QUARTER : (speed ? `SAC_DIV_FULL : `SAC_DIV_HALF);

    sac_clkdiv u_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .run(run),
        .div_code(div_code),
        .tick(tick)
    );

    sac_sar #(
        .WIDTH(WIDTH)
    ) u_sar (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .tick(tick),
        .run(run),
        .restart(restart),
        .comp_high(comp_high),
        .sampling(sar_sampling),
        .trial(sar_trial),
        .done(sar_done),
        .value(sar_value)
    );

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Reserved bits are masked off so stray ones never land
    always @(posedge mclk) begin
        if (sys_rst) begin
            speed <= 1'b0;
            converter_on <= 1'b0;
            channel_select <= 3'h0;
            slow <= 1'b0;
            x8_gain_select <= 1'b0;
        end else if (ce) begin
            if (csr_write) begin
                speed <= wdata[`SAC_CSR_SPEED];
                converter_on <= wdata[`SAC_CSR_ON];
                channel_select <= wdata[`SAC_CSR_CH_HI:`SAC_CSR_CH_LO];
            end
            if (wr && hit_amp) begin
                slow <= wdata[`SAC_AMP_SLOW];
                x8_gain_select <= wdata[`SAC_AMP_GAIN];
            end
        end
    end

    // ----------------------------------------
    // Stabilization after halt
    // ----------------------------------------
    // Counts converter ticks after wakeup; suppresses done until elapsed
    always @(posedge mclk) begin
        if (sys_rst) begin
            stable_cnt <= 8'h00;
            halt_seen <= 1'b0;
        end else if (ce) begin
            halt_seen <= halt_mode;
            if (halt_mode) begin
                stable_cnt <= STABLE_TICKS[7:0];
            end else if (tick && !stable) begin
                stable_cnt <= stable_cnt - 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Done flag and result
    // ----------------------------------------
    // Set beats clear when they coincide, except a restart abort discards it
    always @(posedge mclk) begin
        if (sys_rst) begin
            done_flag <= 1'b0;
            conversion_result <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (sar_done && stable && !restart) begin
                done_flag <= 1'b1;
                conversion_result <= sar_value;
            end else if (csr_write || result_read) begin
                done_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Read port and outputs
    // ----------------------------------------
    // Read data valid one cycle after the strobe; unmapped reads give zero
    always @(posedge mclk) begin
        if (sys_rst) begin
            rdata <= `SAC_RST_BYTE;
            converter_power <= 1'b0;
            amplifier_power <= 1'b0;
            x8_gain_route <= 1'b0;
            channel_sel_out <= 3'h0;
        end else if (ce) begin
            rdata <= `SAC_RST_BYTE;
            if (rd && hit_csr) begin
                rdata <= {done_flag, speed, converter_on, 2'b00, channel_select};
            end else if (result_read) begin
                rdata <= conversion_result;
            end else if (rd && hit_amp) begin
                rdata <= {4'h0, slow, x8_gain_select, 2'b00};
            end
            converter_power <= run;
            amplifier_power <= run;
            x8_gain_route <= x8_gain_select;
            // Codes above four select input zero
            channel_sel_out <= (channel_select > `SAC_CH_MAX) ? 3'h0 : channel_select;
        end
    end

endmodule

// *** dv/sac_chk_asserts.sv ***
// Port assertions for the converter control.
// Assumes binding onto sac_top; one clock, synchronous reset.
`timescale 1ns/1ps
module sac_chk #(
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire sys_rst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire halt_mode,
    input wire converter_power,
    input wire amplifier_power,
    input wire [2:0] channel_sel_out,
    input wire sample_phase,
    input wire [WIDTH-1:0] trial_value
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Bus steps; reads are spaced one idle cycle by the bench
    sequence s_res_rd; rd && addr == 8'h35; endsequence
    sequence s_csr_rd; rd && addr == 8'h34; endsequence
    sequence s_on_wr; wr && addr == 8'h34 && wdata[5]; endsequence
    AST_RST_CLEAR: assert property (disable iff (1'b0)
        sys_rst ##1 sys_rst |-> !converter_power && !sample_phase) else $error("outputs live in reset");
    AST_AMP_RSV: assert property (rd && addr == 8'h36 |=> rdata[1:0] == 2'h0)
        else $error("amp low bits not zero");
    AST_PWR_PAIR: assert property (amplifier_power == converter_power)
        else $error("amp power differs");
    AST_HALT_OFF: assert property ($rose(halt_mode) |-> ##[1:2] !converter_power)
        else $error("halt left power on");
    AST_CH_RANGE: assert property (channel_sel_out <= 3'h4)
        else $error("channel out of range");
    AST_TRIAL_MSB: assert property ($fell(sample_phase) && converter_power && $past(converter_power) |->
        trial_value == {1'b1, {(WIDTH-1){1'b0}}}) else $error("first trial not msb");
    AST_DONE_RD_CLR: assert property (halt_mode throughout (s_res_rd ##2 s_csr_rd) |=> !rdata[7])
        else $error("flag kept after result read");
    AST_WR_CLR: assert property (s_on_wr ##2 s_csr_rd |=> !rdata[7])
        else $error("flag kept after status write");
endmodule

bind sac_top sac_chk #(.WIDTH(WIDTH)) u_chk (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .halt_mode(halt_mode), .converter_power(converter_power),
    .amplifier_power(amplifier_power), .channel_sel_out(channel_sel_out), .sample_phase(sample_phase),
    .trial_value(trial_value));

// *** dv/sac_front_model.sv ***
// Analog front end: input mux, x8 gain, sample-hold and comparator.
// Assumes levels hold five 8-bit inputs, input zero lowest.
`timescale 1ns/1ps
module sac_front_model (
    input wire mclk,
    input wire [39:0] levels,
    input wire [2:0] channel,
    input wire gain,
    input wire sample,
    input wire [7:0] trial,
    output wire comp_high
);
    logic [10:0] amp;
    logic [7:0] held = 8'h00;
    // Gain path clips at full scale, no overflow flag
    assign amp = gain ? {levels[channel*8 +: 8], 3'h0} : {3'h0, levels[channel*8 +: 8]};
    // Capacitor tracks while sampling, held during the steps
    always @(posedge mclk) begin
        if (sample) begin
            held <= (amp > 11'h0ff) ? 8'hff : amp[7:0];
        end
    end
    assign comp_high = (held >= trial);
endmodule

// *** dv/tb_sar_adc_control_8bit.sv ***
// Self-checking bench of the converter control with the front model.
// Assumes sac_top ports; stabilization shortened to 2 ticks.
`timescale 1ns/1ps
module tb_sar_adc_control_8bit;
    typedef struct {logic [7:0] amp; logic [7:0] csr; logic [7:0] res; logic [2:0] ch; int slen;} sac_row_t;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic wait_mode = 1'b0;
    logic halt_mode = 1'b0;
    logic [7:0] rdata, trial_value, d;
    logic comp_high, converter_power, amplifier_power, x8_gain_route, sample_phase;
    logic [2:0] channel_sel_out;
    logic [39:0] levels = 40'h40_13_00_ff_5a;
    int n_errors = 0;
    int n_compared = 0;
    int k;
    // Rows: amp, csr, result, channel, sample length in mclk
    // Status writes keep bits 4:3 at zero gain rows accept a fast clock in sim
    // A status write after each amp write restarts, so no stale conversion is used
    sac_row_t rows [6] = '{'{8'h00, 8'h20, 8'h5a, 3'h0, 8}, '{8'h00, 8'h61, 8'hff, 3'h1, 4},
        '{8'h08, 8'h62, 8'h00, 3'h2, 16}, '{8'h04, 8'h23, 8'h98, 3'h3, 8},
        '{8'h0f, 8'h24, 8'hff, 3'h4, 16}, '{8'h00, 8'h67, 8'h5a, 3'h0, 4}};
    sac_top #(.WIDTH(8), .STABLE_TICKS(8'h02)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wait_mode(wait_mode), .halt_mode(halt_mode),
        .comp_high(comp_high), .converter_power(converter_power), .amplifier_power(amplifier_power),
        .x8_gain_route(x8_gain_route), .channel_sel_out(channel_sel_out), .sample_phase(sample_phase),
        .trial_value(trial_value));
    sac_front_model u_front (.mclk(mclk), .levels(levels), .channel(channel_sel_out), .gain(x8_gain_route),
        .sample(sample_phase), .trial(trial_value), .comp_high(comp_high));
    // Clock 250 MHz
    always #2 mclk = ~mclk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Poll the flag; bounded so a stuck converter fails
    task automatic wait_done;
        k = 0;
        d = 8'h00;
        while (d[7] !== 1'b1 && k < 300) begin
            rd_reg(8'h34);
            k++;
        end
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog, about forty times the expected run
    initial begin
        #100000;
        n_errors++;
        results;
    end
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wait_mode <= i[0];
            wr_reg(8'h36, rows[i].amp);
            wr_reg(8'h34, rows[i].csr);
            wait_done;
            check(d, 8'h80 | (rows[i].csr & 8'h67));
            rd_reg(8'h36);
            check(d, rows[i].amp & 8'h0c);
            rd_reg(8'h35);
            check(d, rows[i].res);
            check({5'h00, channel_sel_out}, {5'h00, rows[i].ch});
            check({7'h00, x8_gain_route}, {7'h00, rows[i].amp[2]});
            // Next conversion starts unprompted; its sample length shows the rate
            @(posedge sample_phase);
            k = 0;
            while (sample_phase === 1'b1 && k < 40) begin
                @(posedge mclk);
                #1 k++;
            end
            check(k[7:0], rows[i].slen[7:0]);
            $display("row %0d finished", i);
        end
        // Halt keeps the flag until the result is read; result ignores writes
        wait_done;
        @(posedge mclk);
        halt_mode <= 1'b1;
        repeat (3) @(posedge mclk);
        check({7'h00, converter_power}, 8'h00);
        wr_reg(8'h35, 8'h33);
        rd_reg(8'h35);
        check(d, 8'h5a);
        rd_reg(8'h34);
        check(d & 8'h80, 8'h00);
        halt_mode <= 1'b0;
        wait_done;
        check(d & 8'h80, 8'h80);
        // Write while on aborts and converts the new channel
        wr_reg(8'h34, 8'h21);
        rd_reg(8'h34);
        check(d, 8'h21);
        wait_done;
        rd_reg(8'h35);
        check(d, 8'hff);
        wr_reg(8'h34, 8'h00);
        repeat (100) @(posedge mclk);
        rd_reg(8'h34);
        check(d, 8'h00);
        rd_reg(8'h40);
        check(d, 8'h00);
        $display("halt, abort and stop finished");
        // Second reset while converting
        wr_reg(8'h36, 8'h0c);
        wr_reg(8'h34, 8'h20);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 8'h34; a < 8'h37; a++) begin
            rd_reg(a[7:0]);
            check(d, 8'h00);
        end
        $display("reset finished");
        results;
    end
endmodule
